// ==== design/olsc_list_sched.sv ====
`timescale 1ns/100ps
`include "olsc_regs.svh"
// Behaviour
// - state codes: reset, resume, run, suspend
// - start-of-frame begins 1 ms after run
// - software reset enters suspend
// - hardware reset: reset state, hub, port reset
// - bulk enable acts next frame, sampled
// - bulk clear stops at once
// - control enable acts next frame, clear stops
// - control enable checked before each service
// - iso descriptor with enable: continue periodic
// - iso descriptor without enable: leave periodic
// - iso enable takes effect next frame
// - periodic enable and clear both act next frame
// - periodic enable checked before periodic start
// - ratio field gives 1:1 to 4:1
// - ratio vs control count picks control/bulk
// - control count kept across frames
module olsc_list_sched #(
  parameter int unsigned SOF_DELAY_CYC = `OLSC_SOF_DELAY_CYC,
  parameter int unsigned FRAME_CYC = `OLSC_FRAME_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic resume_detect,
  input wire logic desc_req,
  input wire logic desc_iso,
  input wire logic desc_nonempty,
  input wire logic periodic_done,
  output logic [1:0] list_sel,
  output logic list_valid,
  output logic sof_out,
  output logic hub_reset,
  output logic port_reset
);

  // bus side
  logic wr_pend_r;
  logic rd_hit;
  logic word_acc;
  logic [7:0] addr_r;
  logic [1:0] fs_r;
  logic ble_r;
  logic cle_r;
  logic ie_r;
  logic ple_r;
  logic [1:0] ratio_r;
  logic [31:0] ctrl_word;
  logic [31:0] sched_word;
  // list side
  logic fr_ble_r;
  logic fr_cle_r;
  logic fr_ie_r;
  logic fr_ple_r;
  logic [2:0] ctrl_cnt_r;
  logic periodic_open_r;
  logic sof_pulse;
  logic resume_s1_r;
  logic resume_s2_r;
  logic sw_reset;
  logic ctrl_wr;
  logic running;
  logic periodic_ok;
  logic ctrl_ok;
  logic bulk_ok;
  logic ctrl_turn;
  logic [1:0] pick_nxt;
  logic [2:0] hw_rst_r;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
    addr_is = (a == ref_a);
  endfunction

  // write data phase aimed at one register
  function automatic logic wr_to(input logic pend, input logic [7:0] a, input logic [7:0] ref_a);
    wr_to = pend && addr_is(a, ref_a);
  endfunction

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_r <= hsel && htrans[1] && hwrite && word_acc;
      addr_r <= haddr[7:0];
    end
  end

  assign word_acc = (hsize == `OLSC_HSIZE_WORD);
  assign rd_hit = hsel && htrans[1] && !hwrite && hready && word_acc;
  assign ctrl_wr = wr_to(wr_pend_r, addr_r, `OLSC_ADDR_CONTROL);
  assign sw_reset = wr_to(wr_pend_r, addr_r, `OLSC_ADDR_SCHED) && hwdata[`OLSC_SWRST_BIT];
  assign running = (fs_r == olsc_pkg::state_running);
  assign ctrl_word = {24'h00_0000, fs_r, ble_r, cle_r, ie_r, ple_r, ratio_r};
  assign sched_word = {25'h000_0000, ctrl_cnt_r, list_valid, 1'b0, list_sel};

  // bus answers: zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data taken in the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_hit)
    begin
      if (addr_is(haddr[7:0], `OLSC_ADDR_CONTROL))
        hrdata <= ctrl_word;
      else if (addr_is(haddr[7:0], `OLSC_ADDR_SCHED))
        hrdata <= sched_word;
      else
        hrdata <= 32'h0000_0000;
    end
  end

  // resume pin synchroniser
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      resume_s1_r <= 1'b0;
      resume_s2_r <= 1'b0;
    end
    else
    begin
      resume_s1_r <= resume_detect;
      resume_s2_r <= resume_s1_r;
    end
  end

  // functional state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fs_r <= olsc_pkg::state_bus_reset;
    else if (sw_reset)
      fs_r <= olsc_pkg::state_suspended;
    else if (ctrl_wr)
      fs_r <= hwdata[`OLSC_FS_HI:`OLSC_FS_LO];
    else if (fs_r == olsc_pkg::state_suspended && resume_s2_r)
      fs_r <= olsc_pkg::state_resuming;
  end

  // list enable bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ble_r <= 1'b0;
      cle_r <= 1'b0;
      ie_r <= 1'b0;
      ple_r <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      ble_r <= hwdata[`OLSC_BLE_BIT];
      cle_r <= hwdata[`OLSC_CLE_BIT];
      ie_r <= hwdata[`OLSC_IE_BIT];
      ple_r <= hwdata[`OLSC_PLE_BIT];
    end
  end

  // service ratio, only software restores it after reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ratio_r <= `OLSC_RATIO_RST;
    else if (ctrl_wr)
      ratio_r <= hwdata[`OLSC_RATIO_HI:`OLSC_RATIO_LO];
  end

  // hub reset span after hardware reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hw_rst_r <= 3'h0;
    else if (hw_rst_r != `OLSC_HUB_RST_CYC)
      hw_rst_r <= hw_rst_r + 3'h1;
  end

  // hub first, then ports while in reset state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hub_reset <= 1'b1;
      port_reset <= 1'b0;
    end
    else
    begin
      hub_reset <= (hw_rst_r != `OLSC_HUB_RST_CYC);
      port_reset <= (hw_rst_r == `OLSC_HUB_RST_CYC)
        && (fs_r == olsc_pkg::state_bus_reset);
    end
  end

  // start-of-frame timing
  olsc_sof_timer #(
    .START_CYC(SOF_DELAY_CYC),
    .FRAME_CYC(FRAME_CYC)
  ) u_sof (
    .hclk(hclk),
    .hresetn(hresetn),
    .running(running),
    .sof_pulse(sof_pulse)
  );

  // start-of-frame pin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sof_out <= 1'b0;
    else
      sof_out <= sof_pulse;
  end

  // bulk enable of this frame, dropped at once when cleared
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fr_ble_r <= 1'b0;
    else if (sof_pulse)
      fr_ble_r <= ble_r;
    else
      fr_ble_r <= fr_ble_r && ble_r;
  end

  // control enable of this frame, dropped at once when cleared
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fr_cle_r <= 1'b0;
    else if (sof_pulse)
      fr_cle_r <= cle_r;
    else
      fr_cle_r <= fr_cle_r && cle_r;
  end

  // iso enable only moves at frame start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fr_ie_r <= 1'b0;
    else if (sof_pulse)
      fr_ie_r <= ie_r;
  end

  // periodic enable only moves at frame start
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fr_ple_r <= 1'b0;
    else if (sof_pulse)
      fr_ple_r <= ple_r;
  end

  // periodic phase of each frame
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      periodic_open_r <= 1'b0;
    else if (sof_pulse)
      periodic_open_r <= ple_r;
    else if (periodic_done)
      periodic_open_r <= 1'b0;
    else if (desc_req && periodic_open_r && desc_iso && !fr_ie_r)
      periodic_open_r <= 1'b0;
  end

  // list eligibility for this pick
  assign periodic_ok = periodic_open_r && fr_ple_r && !(desc_iso && !fr_ie_r);
  assign ctrl_ok = fr_cle_r && cle_r;
  assign bulk_ok = fr_ble_r && ble_r;
  assign ctrl_turn = (ctrl_cnt_r <= {1'b0, ratio_r});

  // pick next list
  always_comb
  begin
    pick_nxt = olsc_pkg::olsc_list_none;
    if (periodic_ok)
      pick_nxt = olsc_pkg::olsc_list_periodic;
    else if (ctrl_ok && (ctrl_turn || !bulk_ok))
      pick_nxt = olsc_pkg::olsc_list_control;
    else if (bulk_ok)
      pick_nxt = olsc_pkg::olsc_list_bulk;
  end

  // chosen list, held until the next request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      list_sel <= olsc_pkg::olsc_list_none;
    else if (desc_req)
      list_sel <= pick_nxt;
  end

  // one-cycle answer, only while running
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      list_valid <= 1'b0;
    else
      list_valid <= desc_req && (pick_nxt != olsc_pkg::olsc_list_none)
        && running;
  end

  // control descriptor count, kept over frames
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_cnt_r <= 3'h0;
    else if (list_valid && list_sel == olsc_pkg::olsc_list_bulk)
      ctrl_cnt_r <= 3'h0;
    else if (list_valid && list_sel == olsc_pkg::olsc_list_control && desc_nonempty)
      ctrl_cnt_r <= (ctrl_cnt_r == `OLSC_CNT_MAX) ? ctrl_cnt_r : ctrl_cnt_r + 3'h1;
  end
endmodule // olsc_list_sched

// ==== design/olsc_pkg.sv ====
package olsc_pkg;
  typedef enum logic [1:0]
  {
    state_bus_reset = 2'b00,
    state_resuming = 2'b01,
    state_running = 2'b10,
    state_suspended = 2'b11
  } olsc_fs_type;
  typedef enum logic [1:0]
  {
    olsc_list_none,
    olsc_list_periodic,
    olsc_list_control,
    olsc_list_bulk
  } olsc_list_type;
endpackage

// ==== design/olsc_regs.svh ====
`ifndef OLSC_REGS_SVH
`define OLSC_REGS_SVH
`define OLSC_ADDR_CONTROL 8'h04
`define OLSC_ADDR_SCHED 8'h40
`define OLSC_FS_LO 6
`define OLSC_FS_HI 7
`define OLSC_BLE_BIT 5
`define OLSC_CLE_BIT 4
`define OLSC_IE_BIT 3
`define OLSC_PLE_BIT 2
`define OLSC_RATIO_HI 1
`define OLSC_RATIO_LO 0
`define OLSC_SWRST_BIT 0
`define OLSC_SOF_DELAY_US 1000
`define OLSC_CLK_MHZ 20
`define OLSC_SOF_DELAY_CYC (`OLSC_SOF_DELAY_US * `OLSC_CLK_MHZ)
`define OLSC_FRAME_CYC 20000
`define OLSC_RATIO_RST 2'h0
`define OLSC_HUB_RST_CYC 3'h7
`define OLSC_CNT_MAX 3'h4
`define OLSC_HSIZE_WORD 3'h2
`endif

// ==== design/olsc_sof_timer.sv ====
`timescale 1ns/100ps
`include "olsc_regs.svh"
module olsc_sof_timer #(
  parameter int unsigned START_CYC = `OLSC_SOF_DELAY_CYC,
  parameter int unsigned FRAME_CYC = `OLSC_FRAME_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic running,
  output logic sof_pulse
);
  logic [15:0] cnt_r;
  logic started_r;
  // start delay then frame-periodic start-of-frame
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= 16'h0000;
      started_r <= 1'b0;
      sof_pulse <= 1'b0;
    end
    else if (!running)
    begin
      cnt_r <= 16'h0000;
      started_r <= 1'b0;
      sof_pulse <= 1'b0;
    end
    else if (cnt_r == 16'((started_r ? FRAME_CYC : START_CYC) - 1))
    begin
      cnt_r <= 16'h0000;
      started_r <= 1'b1;
      sof_pulse <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      sof_pulse <= 1'b0;
    end
  end
endmodule // olsc_sof_timer

// ==== testbench/olsc_dev_model.sv ====
`timescale 1ns/100ps
module olsc_dev_model (
  input wire logic hclk,
  input wire logic ask,
  input wire logic iso,
  input wire logic full,
  input wire logic done,
  input wire logic wake,
  output logic desc_req,
  output logic desc_iso,
  output logic desc_nonempty,
  output logic periodic_done,
  output logic resume_detect
);
  always_ff @(posedge hclk)
  begin
    desc_req <= ask;
    desc_iso <= ask ? iso : (desc_req ? desc_iso : (desc_iso !== 1'b1));
    desc_nonempty <= ask ? full : (desc_req ? desc_nonempty : (desc_nonempty !== 1'b1));
    periodic_done <= done;
    resume_detect <= wake;
  end
endmodule // olsc_dev_model

// ==== testbench/olsc_list_sched_chk.sv ====
`timescale 1ns/100ps
module olsc_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic desc_req,
  input wire logic [1:0] list_sel,
  input wire logic list_valid,
  input wire logic sof_out,
  input wire logic hub_reset,
  input wire logic port_reset
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_sof_gap: assert property (sof_out |=> !sof_out [*8]) else $error("sof gap");
  chk_valid_cause: assert property (list_valid |-> $past(desc_req)) else $error("pick");
  chk_valid_list: assert property (list_valid |-> list_sel != 2'h0) else $error("sel");
  chk_hub_start: assert property ($rose(hresetn) |-> hub_reset [*4]) else $error("hub");
  chk_hub_end: assert property ($rose(hresetn) |-> ##[1:12] !hub_reset) else $error("hub");
  chk_port_hub: assert property (port_reset |-> !hub_reset) else $error("port");
  chk_port_next: assert property ($fell(hub_reset) |-> ##[0:2] port_reset) else $error("port");
  chk_reset_quiet: assert property (port_reset |-> !sof_out && !list_valid) else $error("q");
  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus response");
endmodule // olsc_chk
bind olsc_list_sched olsc_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .desc_req(desc_req), .list_sel(list_sel), .list_valid(list_valid),
  .sof_out(sof_out), .hub_reset(hub_reset), .port_reset(port_reset));

// ==== testbench/olsc_list_sched_tb_top.sv ====
`timescale 1ns/100ps
module olsc_list_sched_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic ask = 1'b0;
  logic iso = 1'b0;
  logic full = 1'b0;
  logic done = 1'b0;
  logic wake = 1'b0;
  logic [31:0] hrdata, q;
  logic [1:0] list_sel;
  logic hreadyout, hresp, desc_req, desc_iso, desc_nonempty, periodic_done, resume_detect;
  logic list_valid, sof_out, hub_reset, port_reset;
  int miscompares = 0;
  int checked = 0;
  int n;
  logic [31:0] rows [5][2] = '{'{32'h0000_0021, 32'h0000_0021}, '{32'h0000_0012, 32'h0000_0012},
    '{32'h0000_000B, 32'h0000_000B}, '{32'hFFFF_FF3C, 32'h0000_003C},
    '{32'h0000_00C3, 32'h0000_00C3}};
  localparam logic [1:0] CTL = olsc_pkg::olsc_list_control;
  localparam logic [1:0] BLK = olsc_pkg::olsc_list_bulk;
  localparam logic [1:0] PER = olsc_pkg::olsc_list_periodic;
  always #25 hclk = ~hclk;
  olsc_list_sched #(.SOF_DELAY_CYC(20), .FRAME_CYC(20)) u_olsc_list_sched (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .resume_detect(resume_detect),
    .desc_req(desc_req), .desc_iso(desc_iso), .desc_nonempty(desc_nonempty),
    .periodic_done(periodic_done), .list_sel(list_sel), .list_valid(list_valid),
    .sof_out(sof_out), .hub_reset(hub_reset), .port_reset(port_reset));
  olsc_dev_model u_olsc_dev_model (.hclk(hclk), .ask(ask), .iso(iso), .full(full),
    .done(done), .wake(wake),
    .desc_req(desc_req), .desc_iso(desc_iso), .desc_nonempty(desc_nonempty),
    .periodic_done(periodic_done), .resume_detect(resume_detect));
  task end_of_test;
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task pick(input logic i, input logic f, input logic [1:0] e);
    @(posedge hclk);
    {ask, iso, full} <= {1'b1, i, f};
    @(posedge hclk);
    ask <= 1'b0;
    @(posedge hclk);
    #1 chk({list_valid, list_sel}, {e != 2'h0, e});
  endtask
  task sof;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (sof_out !== 1'b1 && n < 200);
    if (n >= 200)
      miscompares++;
  endtask
  initial
  begin
    #(50 * 3000);
    miscompares++;
    end_of_test;
  end
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 32'h04, 0);
    chk(q, 0);
    chk(hub_reset, 1);
    repeat (12) @(posedge hclk);
    #1 chk({hub_reset, port_reset}, 2'b01);
    for (int i = 0; i < 5; i++)
    begin
      bus(1, 32'h04, rows[i][0]);
      bus(0, 32'h04, 0);
      chk(q, rows[i][1]);
    end
    bus(0, 32'h10, 0);
    chk(q, 0);
    bus(1, 32'h04, 32'h0000_0034);
    bus(1, 32'h40, 1);
    bus(0, 32'h04, 0);
    chk(q, 32'h0000_00F4);
    bus(1, 32'h04, 32'h0000_00B1);
    sof;
    chk(n >= 20 && n <= 23, 1);
    pick(0, 1, CTL);
    sof;
    pick(0, 1, CTL);
    pick(0, 1, BLK);
    pick(0, 1, CTL);
    bus(1, 32'h04, 32'h0000_0091);
    sof;
    pick(0, 1, CTL);
    pick(0, 1, CTL);
    bus(1, 32'h04, 32'h0000_0081);
    sof;
    pick(0, 1, 2'h0);
    bus(1, 32'h04, 32'h0000_00A1);
    sof;
    pick(0, 1, BLK);
    bus(1, 32'h04, 32'h0000_00A4);
    sof;
    pick(0, 0, PER);
    pick(1, 0, BLK);
    pick(0, 0, BLK);
    sof;
    bus(1, 32'h04, 32'h0000_00AC);
    pick(1, 0, BLK);
    sof;
    pick(1, 0, PER);
    @(posedge hclk);
    done <= 1'b1;
    @(posedge hclk);
    done <= 1'b0;
    pick(0, 0, BLK);
    bus(1, 32'h04, 32'h0000_00C0);
    wake <= 1'b1;
    repeat (4) @(posedge hclk);
    wake <= 1'b0;
    bus(0, 32'h04, 0);
    chk(q, 32'h0000_0040);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 32'h04, 0);
    chk(q, 0);
    chk(hub_reset, 1);
    bus(1, 32'h04, 32'h0000_0010);
    bus(0, 32'h04, 0);
    chk(q, 32'h0000_0010);
    end_of_test;
  end
endmodule // olsc_list_sched_tb_top
